// ### core/bank_decode_defs.vh
// Address decode constants for the bank strobe and palette decoder
`ifndef BANK_DECODE_DEFS_VH
`define BANK_DECODE_DEFS_VH
`define HI_NIB_LSB      28
`define BANK_SEL_LSB    23
`define REG_SEL_LSB     5
`define HI_NIB_PALETTE  4'hd
`define HI_NIB_SHADOW   4'hf
`define BANK_VRAM0      2'h0
`define BANK_VRAM1      2'h1
`define BANK_DRAM       2'h2
`define BANK_SHADOW     2'h3
`define STATUS_LD_MASK  4'h3
`define STATUS_LD_COLOR 4'h4
`define REG_SEL_RESET   4'hf
`endif

// ### core/addr_latch.v
// Transparent address and status latch with hold between address phases
`timescale 1ns/1ps
`include "bank_decode_defs.vh"
module addr_latch (
	input  wire        ref_clk_i,     // Bus clock
	input  wire        reset_n_i,     // Synchronous reset, active low
	input  wire        addr_phase_i,  // Address phase of the local bus cycle
	input  wire [31:0] lad_i,         // Local address/data bus
	input  wire [3:0]  status_i,      // Bus cycle status code
	output wire [3:0]  hi_nib_o,      // Address bits 31..28
	output wire [1:0]  bank_sel_o,    // Address bits 24..23
	output wire [3:0]  status_o,      // Status bits 3..0
	output wire [3:0]  reg_sel_o      // Address bits 8..5
);
	reg [3:0] hi_hold;
	reg [1:0] bank_hold;
	reg [3:0] stat_hold;
	reg [3:0] rsel_hold;
	// Held copies feed back so the outputs keep their value while closed; they follow input while open
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			hi_hold   <= 4'h0;
			bank_hold <= 2'h0;
			stat_hold <= 4'h0;
			rsel_hold <= `REG_SEL_RESET; // see RULE_16
		end else if (addr_phase_i) begin // see RULE_17
			hi_hold   <= lad_i[31:28];
			bank_hold <= lad_i[24:23];
			stat_hold <= status_i;
			rsel_hold <= lad_i[8:5];
		end
	end
	assign hi_nib_o   = addr_phase_i ? lad_i[31:28] : hi_hold; // see RULE_15
	assign bank_sel_o = addr_phase_i ? lad_i[24:23] : bank_hold; // see RULE_14
	assign status_o   = addr_phase_i ? status_i : stat_hold; // see RULE_14
	assign reg_sel_o  = !reset_n_i ? `REG_SEL_RESET :
		(addr_phase_i ? lad_i[8:5] : rsel_hold); // see RULE_16
endmodule // addr_latch

// ### core/bank_decoder.v
// Row strobe bank decoder and palette strobe generator
`timescale 1ns/1ps
`include "bank_decode_defs.vh"
//Contract
// RULE_01: Bank 0 at zero, bank 1 at 0x00800000, DRAM up to 0x017FFFFF.
// RULE_02: Bank strobes come from processor row strobe and latched address.
// RULE_03: DRAM also answers in shadow from 0xFF800000 covering vectors.
// RULE_04: Decode is incomplete; every bank aliases through address space.
// RULE_05: Mask and color load cycles strobe both video RAM banks.
// RULE_06: DRAM strobe stays off during mask and color load cycles.
// RULE_07: Processor drives zero address in mask and color load cycles.
// RULE_08: Active-low palette select in the region near 0xD0000000.
// RULE_09: Palette write strobe low when select low and write enable low.
// RULE_10: Palette read low when select low, write high, transfer low.
// RULE_11: Palette register selects come from latched address bits 8..5.
// RULE_12: Only low eight data bits of palette words are meaningful.
// RULE_13: Software should use byte accesses at word-aligned addresses.
// RULE_14: Latch holds address bits 31..28, 24..23 and status 3..0.
// RULE_15: Select latch is transparent, built with internal feedback.
// RULE_16: Reset forces latched address bits 8..5 high.
// RULE_17: Latch passes in address phase, holds until the next one.
module bank_decoder (
	input  wire        ref_clk_i,                   // Bus clock
	input  wire        reset_n_i,                   // Sync reset, low
	input  wire        addr_phase_i,                // Address phase strobe
	input  wire [31:0] local_addr_data_bus_i,       // Muxed bus
	input  wire [3:0]  status_i,                    // Cycle status
	input  wire        processor_row_strobe_out_n_i, // Row strobe, low
	input  wire        write_enable_n_i,            // Write enable, low
	input  wire        transfer_output_enable_n_i,  // Transfer/OE, low
	output reg         vram_bank0_row_strobe_n_o,   // Bank 0 strobe
	output reg         vram_bank1_row_strobe_n_o,   // Bank 1 strobe
	output reg         dram_bank_row_strobe_n_o,    // DRAM strobe
	output reg         palette_chip_select_n_o,     // Palette select
	output reg         palette_write_n_o,           // Palette write
	output reg         palette_read_n_o,            // Palette read
	output reg  [3:0]  palette_reg_sel_o            // Register select
);
	wire [3:0] hi_nib;
	wire [1:0] bank_sel;
	wire [3:0] stat;
	wire [3:0] reg_sel;
	reg        special;
	reg        next_b0;
	reg        next_b1;
	reg        next_dr;
	reg        next_cs;
	reg        mem_region;

	addr_latch latch_decoder (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.addr_phase_i(addr_phase_i),
		.lad_i       (local_addr_data_bus_i),
		.status_i    (status_i),
		.hi_nib_o    (hi_nib),
		.bank_sel_o  (bank_sel),
		.status_o    (stat),
		.reg_sel_o   (reg_sel)
	);

	// Zero address in special cycles is not relied on; status alone decodes them
	always @* begin
		special = (stat == `STATUS_LD_MASK) ||
			(stat == `STATUS_LD_COLOR); // see RULE_07
		// Only top nibble and bits 24..23 decoded, so banks alias
		mem_region = (hi_nib != `HI_NIB_PALETTE); // see RULE_04
		next_b0 = 1'b1;
		next_b1 = 1'b1;
		next_dr = 1'b1;
		next_cs = 1'b1;
		if (!processor_row_strobe_out_n_i) begin // see RULE_02
			if (special) begin
				next_b0 = 1'b0; // see RULE_05
				next_b1 = 1'b0; // see RULE_05
				next_dr = 1'b1; // see RULE_06
			end else if (hi_nib == `HI_NIB_SHADOW &&
				bank_sel == `BANK_SHADOW) begin
				next_dr = 1'b0; // see RULE_03
			end else if (mem_region) begin
				case (bank_sel)
					`BANK_VRAM0: next_b0 = 1'b0; // see RULE_01
					`BANK_VRAM1: next_b1 = 1'b0; // see RULE_01
					`BANK_DRAM:  next_dr = 1'b0; // see RULE_01
					default:     next_dr = 1'b0; // see RULE_04
				endcase
			end
		end
		if (!addr_phase_i && hi_nib == `HI_NIB_PALETTE && !special)
			next_cs = 1'b0; // see RULE_08
	end

	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			vram_bank0_row_strobe_n_o <= 1'b1;
			vram_bank1_row_strobe_n_o <= 1'b1;
			dram_bank_row_strobe_n_o  <= 1'b1;
			palette_chip_select_n_o   <= 1'b1;
			palette_write_n_o         <= 1'b1;
			palette_read_n_o          <= 1'b1;
			palette_reg_sel_o         <= `REG_SEL_RESET; // see RULE_16
		end else begin
			vram_bank0_row_strobe_n_o <= next_b0;
			vram_bank1_row_strobe_n_o <= next_b1;
			dram_bank_row_strobe_n_o  <= next_dr;
			palette_chip_select_n_o   <= next_cs;
			palette_write_n_o <= next_cs | write_enable_n_i; // see RULE_09
			palette_read_n_o  <= next_cs | !write_enable_n_i |
				transfer_output_enable_n_i; // see RULE_10
			palette_reg_sel_o <= reg_sel; // see RULE_11
		end
	end
endmodule // bank_decoder

// ### sim/decode_props.sv
// Assertions on the bank strobe and palette decoder ports
`timescale 1ns/1ps
module decode_props (
	input wire        ref_clk_i, reset_n_i, addr_phase_i, write_enable_n_i,
	input wire        processor_row_strobe_out_n_i, transfer_output_enable_n_i,
	input wire [31:0] local_addr_data_bus_i,
	input wire [3:0]  status_i, palette_reg_sel_o,
	input wire        vram_bank0_row_strobe_n_o, vram_bank1_row_strobe_n_o,
	input wire        dram_bank_row_strobe_n_o, palette_chip_select_n_o,
	input wire        palette_write_n_o, palette_read_n_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire [1:0] bk = local_addr_data_bus_i[24:23];
	wire [3:0] hi = local_addr_data_bus_i[31:28];
	wire [3:0] rsel = local_addr_data_bus_i[8:5];
	wire sp = status_i == 4'h3 || status_i == 4'h4;
	wire cs = palette_chip_select_n_o;
	wire [2:0] rows = {vram_bank0_row_strobe_n_o, vram_bank1_row_strobe_n_o,
		dram_bank_row_strobe_n_o};
	sequence mem_cyc(c);
		(addr_phase_i && c) ##1 (!addr_phase_i && !processor_row_strobe_out_n_i);
	endsequence
	a_reset_high: assert property (disable iff (1'b0) !reset_n_i |=>
		{rows, cs, palette_write_n_o, palette_read_n_o, palette_reg_sel_o} == 10'h3ff)
		else $error("outputs not idle after reset");
	a_load_both: assert property (mem_cyc(sp) |=> rows == 3'h1)
		else $error("special cycle strobes wrong");
	a_dram_decode: assert property (mem_cyc(!sp && hi != 4'hd) |=>
		rows[0] == ($past(bk, 2) < 2'h2)) else $error("dram strobe wrong");
	a_vram_decode: assert property (mem_cyc(!sp && hi != 4'hd) |=>
		rows[2:1] == ~{$past(bk, 2) == 2'h0, $past(bk, 2) == 2'h1})
		else $error("video bank strobe wrong");
	a_sel_hold: assert property (addr_phase_i ##1 !addr_phase_i |=>
		palette_reg_sel_o == $past(rsel, 2)) else $error("register select wrong");
	a_cs_phase: assert property (addr_phase_i |=> cs)
		else $error("palette select in address phase");
	a_write_cause: assert property (!palette_write_n_o |->
		!cs && !$past(write_enable_n_i)) else $error("palette write wrong");
	a_read_cause: assert property (!palette_read_n_o |-> !cs &&
		$past(write_enable_n_i) && !$past(transfer_output_enable_n_i))
		else $error("palette read wrong");
	cover property (mem_cyc(sp));
	cover property (!palette_write_n_o);
	cover property (!palette_read_n_o);
endmodule // decode_props
bind bank_decoder decode_props props (.*);

// ### sim/cpu_bus_model.sv
// Local bus master model that runs address and row strobe cycles
`timescale 1ns/1ps
module cpu_bus_model (
	input  wire         ref_clk_i,    // Bus clock
	output logic        addr_phase_o, // Address phase
	output logic [31:0] lad_o,        // Address/data bus
	output logic [3:0]  status_o,     // Cycle status
	output logic [2:0]  ctl_n_o       // Row strobe, write enable, transfer
);
	initial {addr_phase_o, lad_o, status_o, ctl_n_o} = {37'h0, 3'h7};
	task start(input [31:0] a, input [3:0] s, input w, input t);
		@(negedge ref_clk_i);
		addr_phase_o = 1'b1;
		lad_o = (s == 4'h3 || s == 4'h4) ? 32'h0 : a;
		status_o = s;
		@(negedge ref_clk_i);
		{addr_phase_o, ctl_n_o} = {2'b00, w, t};
		lad_o = ~lad_o;
		@(negedge ref_clk_i);
	endtask
	task stop;
		ctl_n_o = 3'h7;
		lad_o = ~lad_o;
	endtask
endmodule // cpu_bus_model

// ### sim/testbench.sv
// Self-checking bench for the bank strobe and palette decoder
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst_n = 0, ph, v0, v1, dr, cs, wr, rd;
	logic [31:0] local_addr_data_bus;
	logic [3:0] st, sel;
	logic [2:0] ctl;
	int num_errors = 0, checks_done = 0, cyc = 0;
	cpu_bus_model cpu (.ref_clk_i(clk), .addr_phase_o(ph), .lad_o(local_addr_data_bus),
		.status_o(st), .ctl_n_o(ctl));
	bank_decoder DUT (.ref_clk_i(clk), .reset_n_i(rst_n), .addr_phase_i(ph),
		.local_addr_data_bus_i(local_addr_data_bus), .status_i(st),
		.processor_row_strobe_out_n_i(ctl[2]), .write_enable_n_i(ctl[1]),
		.transfer_output_enable_n_i(ctl[0]), .vram_bank0_row_strobe_n_o(v0),
		.vram_bank1_row_strobe_n_o(v1), .dram_bank_row_strobe_n_o(dr),
		.palette_chip_select_n_o(cs), .palette_write_n_o(wr),
		.palette_read_n_o(rd), .palette_reg_sel_o(sel));
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (++cyc == 2000) begin
		num_errors++;
		complete_run;
	end
	task complete_run;
		if (num_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input logic [9:0] e);
		checks_done++;
		if ({v0, v1, dr, cs, wr, rd, sel} !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, {v0, v1, dr, cs, wr, rd, sel});
		end
	endtask
	task run(input string n, input [31:0] a, input [3:0] s, input w, t);
		logic sp, pal;
		sp = s == 4'h3 || s == 4'h4;
		pal = a[31:28] == 4'hd && !sp;
		cpu.start(a, s, w, t);
		chk(n, {!(sp || (!pal && a[24:23] == 2'h0)),
			!(sp || (!pal && a[24:23] == 2'h1)),
			sp || pal || !a[24], !pal, !pal | w, !pal | !w | t, a[8:5]});
		cpu.stop;
	endtask
	task sc_banks;
		static logic [31:0] tb [7] = '{32'h0, 32'h00800000, 32'h01000000,
			32'h017fffff,
			32'hff800000, 32'hfff00000, 32'h30800000};
		foreach (tb[i]) run("bank", tb[i], 4'h0, 1'b1, 1'b1);
	endtask
	task sc_special;
		run("mask", 32'h0, 4'h3, 1'b0, 1'b1);
		run("color", 32'h0, 4'h4, 1'b1, 1'b1);
	endtask
	task sc_palette;
		run("pal_wr", 32'hd0000020, 4'h0, 1'b0, 1'b1);
		run("pal_rd", 32'hd00001e0, 4'h0, 1'b1, 1'b0);
		run("pal_rd_tr", 32'hd0000100, 4'h0, 1'b1, 1'b1);
	endtask
	task sc_reset;
		cpu.start(32'hd00000c0, 4'h0, 1'b0, 1'b1);
		rst_n = 0;
		@(negedge clk);
		chk("reset", 10'h3ff);
		rst_n = 1;
		cpu.stop;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1;
		sc_banks;
		sc_special;
		sc_palette;
		sc_reset;
		sc_palette;
		complete_run;
	end
endmodule // testbench
